// ==== hw/eac_pkg.sv ====
package eac_pkg;

    // register block and array map
    localparam logic [15:0] EAC_OFS_MCR      = 16'h00F0;
    localparam logic [15:0] EAC_OFS_PROT     = 16'h00F1;
    localparam logic [15:0] EAC_OFS_SPARE    = 16'h00F2;
    localparam logic [15:0] EAC_OFS_PGMCTL   = 16'h00F3;
    localparam logic [15:0] EAC_OFS_PRESCALE = 16'h00EE;
    localparam logic [15:0] EAC_ARRAY_LO     = 16'h0C00;
    localparam logic [15:0] EAC_ARRAY_HI     = 16'h0FFF;
    localparam logic [9:0]  EAC_SHADOW_IDX   = 10'h3C0;
    localparam logic [9:0]  EAC_REG4_END     = 10'h200;
    localparam logic [9:0]  EAC_REG3_END     = 10'h300;
    localparam logic [9:0]  EAC_REG2_END     = 10'h380;
    localparam logic [9:0]  EAC_REG1_END     = 10'h3C0;
    localparam int          EAC_ARRAY_BYTES  = 1024;

    // module_configuration fields
    localparam int EAC_MCR_DLD = 7;
    localparam int EAC_MCR_SHD = 6;
    localparam int EAC_MCR_WCS = 2;
    localparam int EAC_MCR_PLK = 1;
    localparam int EAC_MCR_PCS = 0;
    // block_protect fields
    localparam int EAC_PROT_SHP = 7;
    // program control fields
    localparam int EAC_PG_BULK_PROTECT = 7;
    localparam int EAC_PG_BYTE  = 4;
    localparam int EAC_PG_ROW   = 3;
    localparam int EAC_PG_ERASE = 2;
    localparam int EAC_PG_LAT   = 1;
    localparam int EAC_PG_PGM   = 0;

    // reset and fixed values
    localparam logic [7:0] EAC_PROT_RESET  = 8'hFF;
    localparam logic [7:0] EAC_PROT_FIXED  = 8'h60;
    localparam logic [7:0] EAC_ERASED      = 8'hFF;
    localparam logic [7:0] EAC_UNDEF_READ  = 8'h00;

    // timing counts
    localparam int EAC_PROG_TICKS = 500;
    localparam int EAC_RC_DIV     = 4;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        rd;
        logic        wr;
        logic        word;
    } eac_bus_req_t;

    typedef struct packed {
        logic [9:0]  idx;
        logic [15:0] data;
        logic        word;
    } eac_latch_t;

endpackage : eac_pkg

// ==== hw/eac_pump.sv ====
`timescale 1ns/10ps
module eac_pump
    import eac_pkg::*;
#(
    parameter int TICKS  = EAC_PROG_TICKS,
    parameter int RC_DIV = EAC_RC_DIV
)(
    input  wire logic ref_clk,    // system clock
    input  wire logic resetn,     // synchronous reset, low
    input  wire logic clk_en,     // module clock enable (wait gating)
    input  wire logic armed,      // program voltage enable bit
    input  wire logic hv_on,      // voltage actually applied
    input  wire logic rc_sel,     // pump clock from rc oscillator
    output logic      rc_run,     // rc oscillator running
    output logic      pulse_done  // one-cycle commit strobe
);

    typedef enum {PM_IDLE, PM_PUMP, PM_DONE} eac_pm_t;

    eac_pm_t     state_q;
    logic [31:0] cnt_q;
    logic [31:0] div_q;
    logic        tick;

    if (TICKS < 1 || RC_DIV < 2) begin : g_bad_param
        $error("eac_pump: TICKS >= 1 and RC_DIV >= 2 required");
    end

    assign rc_run = rc_sel && hv_on;
    // system clock ticks every cycle, rc path through divider
    assign tick   = clk_en && hv_on && (!rc_sel || div_q == 32'(RC_DIV - 1));

    always_ff @(posedge ref_clk)
    begin
        if (!resetn || !rc_run)
            div_q <= '0;
        else if (clk_en)
            div_q <= (div_q == 32'(RC_DIV - 1)) ? '0 : div_q + 32'd1;
    end

    // count holds across stop, restarts only when the enable bit drops
    always_ff @(posedge ref_clk)
    begin
        pulse_done <= 1'b0;
        if (!resetn)
        begin
            state_q <= PM_IDLE;
            cnt_q   <= '0;
        end
        else if (clk_en)
        begin
            case (state_q)
                PM_IDLE:
                begin
                    cnt_q <= '0;
                    if (armed)
                        state_q <= PM_PUMP;
                end
                PM_PUMP:
                begin
                    if (!armed)
                        state_q <= PM_IDLE;
                    else if (tick)
                    begin
                        cnt_q <= cnt_q + 32'd1;
                        if (cnt_q == 32'(TICKS - 1))
                        begin
                            state_q    <= PM_DONE;
                            pulse_done <= 1'b1;
                        end
                    end
                end
                PM_DONE:
                begin
                    if (!armed)
                        state_q <= PM_IDLE;
                end
                default: state_q <= PM_IDLE;
            endcase
        end
    end

endmodule : eac_pump

// ==== hw/eac_top.sv ====
`timescale 1ns/10ps
// How it works
// R01 - byte or aligned word read answers in one cycle, misaligned in two
// R02 - misaligned word program or erase latches only one byte
// R03 - software erases before programming; erased bytes read 0xFF
// R04 - erase by byte, aligned word, 32-byte row or whole array
// R05 - registers decode from 0x00F0, array from 0x0C00 to 0x0FFF
// R06 - array enable gates only array access, never a running operation
// R07 - stop removes voltage and rc clock, keeps enable bit, restores after
// R08 - wait-stop clear keeps running in wait; set gates module clock
// R09 - each reset copies shadow byte into configuration bits 7 to 4
// R10 - shadow enabled maps shadow byte at 0x0FC0 for read and program
// R11 - debug lockout bit: 0 enables lockout; writable in special mode only
// R12 - protection lock freezes protect bits; write once in normal mode
// R13 - pump clock select chooses system clock or rc oscillator
// R14 - block protect writable only with enable and lock both clear
// R15 - block protect resets to ones; bit7 shadow, bits 6,5 fixed one
// R16 - shadow bit6 clear makes the 63 bytes after shadow reserved
// R17 - prescaler word location ignores writes, reads undefined
// R18 - protect bits 4..0 guard 512, 256, 128, 64 and last 64 bytes
// R19 - byte and row select bulk, row or byte erase; ignored in program
// R20 - enable bit sets only with latch already set
// R21 - while enabled, control bits frozen and array writes ignored
module eac_top
    import eac_pkg::*;
#(
    parameter int PROG_TICKS = EAC_PROG_TICKS,
    parameter int RC_DIV     = EAC_RC_DIV
)(
    input  wire logic   ref_clk,             // 25 MHz bus clock
    input  wire logic   resetn,              // synchronous reset, low
    input  eac_bus_req_t bus_req,            // cpu request, one cycle
    input  wire logic   array_access_enable, // array decode enable
    input  wire logic   normal_mode_flag,    // 1 normal, 0 special
    input  wire logic   stop_req,            // chip in stop
    input  wire logic   wait_req,            // chip in wait
    output logic [15:0] bus_rdata_q,         // read data
    output logic        bus_ack_q,           // answer strobe
    output logic        bus_hit,             // address decoded here
    output logic        prog_voltage_on,     // pump output to array
    output logic        rc_osc_run,          // rc oscillator running
    output logic        debug_lockout_en     // debug lockout active
);

    // nonvolatile storage is never reset
    logic [7:0]  mem_q [EAC_ARRAY_BYTES] = '{default: EAC_ERASED};
    logic [7:0]  shadow_q = EAC_ERASED;
    logic [3:0]  mcr_hi_q;
    logic        wcs_q;
    logic        plk_q;
    logic        plk_used_q;
    logic        pcs_q;
    logic [7:0]  prot_q;
    logic [7:0]  pg_q;
    eac_latch_t  latch_q;
    logic        mis_q;
    logic [15:0] mis_addr_q;
    logic        mod_en;
    logic        commit;
    logic        shadow_on;
    logic        in_regs;
    logic        in_pre;
    logic        in_array;
    logic        take_rd;
    logic        take_wr;
    logic        misaligned;
    logic [7:0]  mcr_wr;
    logic [7:0]  pg_wr;

    // gating is a clock enable, so the single clock keeps running
    assign mod_en     = !(wait_req && wcs_q);                    // R08
    assign shadow_on  = !mcr_hi_q[EAC_MCR_SHD - 4];              // R10
    assign in_regs    = bus_req.addr >= EAC_OFS_MCR &&
                        bus_req.addr <= EAC_OFS_PGMCTL;          // R05
    assign in_pre     = bus_req.addr == EAC_OFS_PRESCALE ||
                        bus_req.addr == EAC_OFS_PRESCALE + 16'h0001;
    assign in_array   = bus_req.addr >= EAC_ARRAY_LO &&
                        bus_req.addr <= EAC_ARRAY_HI;            // R05
    assign bus_hit    = in_regs || in_pre ||
                        (in_array && array_access_enable);       // R06
    assign take_rd    = bus_req.rd && bus_hit && mod_en && !mis_q;
    assign take_wr    = bus_req.wr && bus_hit && mod_en && !mis_q;
    assign misaligned = bus_req.word && bus_req.addr[0];
    assign prog_voltage_on  = pg_q[EAC_PG_PGM] && !stop_req;     // R07
    assign debug_lockout_en = !mcr_hi_q[EAC_MCR_DLD - 4];        // R11

    function automatic logic [7:0] mcr_byte();
        return {mcr_hi_q, 1'b0, wcs_q, plk_q, pcs_q};
    endfunction : mcr_byte

    function automatic logic reserved_idx(input logic [9:0] idx);
        return !shadow_q[6] && idx > EAC_SHADOW_IDX;             // R16
    endfunction : reserved_idx

    function automatic logic [7:0] read_byte(input logic [15:0] a);
        logic [7:0] v;
        v = EAC_UNDEF_READ;
        if (a == EAC_OFS_MCR)
            v = mcr_byte();
        else if (a == EAC_OFS_PROT)
            v = prot_q;
        else if (a == EAC_OFS_PGMCTL)
            v = pg_q;
        else if (a >= EAC_ARRAY_LO && a <= EAC_ARRAY_HI)
        begin
            if (a[9:0] == EAC_SHADOW_IDX && shadow_on)
                v = shadow_q;                                    // R10
            else if (reserved_idx(a[9:0]))
                v = EAC_ERASED;                                  // R16
            else
                v = mem_q[a[9:0]];
        end
        return v;
    endfunction : read_byte

    // region protection by array offset
    function automatic logic region_prot(input logic [9:0] idx);
        logic p;
        p = prot_q[0];
        if (idx < EAC_REG4_END)
            p = prot_q[4];
        else if (idx < EAC_REG3_END)
            p = prot_q[3];
        else if (idx < EAC_REG2_END)
            p = prot_q[2];
        else if (idx < EAC_REG1_END)
            p = prot_q[1];
        return p;                                                // R18
    endfunction : region_prot

    function automatic logic in_target(input logic [9:0] idx);
        logic t;
        t = idx == latch_q.idx ||
            (latch_q.word && idx == {latch_q.idx[9:1], 1'b1});
        if (pg_q[EAC_PG_ERASE] && !pg_q[EAC_PG_BYTE])            // R19
            t = pg_q[EAC_PG_ROW] ? idx[9:5] == latch_q.idx[9:5]
                                 : 1'b1;                         // R04
        return t;
    endfunction : in_target

    function automatic logic [7:0] prog_data(input logic [9:0] idx);
        return (latch_q.word && !idx[0]) ? latch_q.data[15:8]
                                         : latch_q.data[7:0];
    endfunction : prog_data

    // byte lane that a bus write places on a register offset
    function automatic logic wr_hits(input logic [15:0] target);
        return bus_req.addr == target ||
               (bus_req.word && bus_req.addr + 16'h0001 == target);
    endfunction : wr_hits

    function automatic logic [7:0] wr_lane(input logic [15:0] target);
        return (bus_req.word && bus_req.addr == target) ?
               bus_req.wdata[15:8] : bus_req.wdata[7:0];
    endfunction : wr_lane

    // always_comb so the function's reads of bus_req are in its sensitivity
    always_comb
    begin
        mcr_wr = wr_lane(EAC_OFS_MCR);
        pg_wr  = wr_lane(EAC_OFS_PGMCTL);
    end

    // read path and misaligned second beat
    always_ff @(posedge ref_clk)
    begin
        bus_ack_q <= 1'b0;
        if (!resetn)
        begin
            bus_rdata_q <= '0;
            mis_q       <= 1'b0;
            mis_addr_q  <= '0;
        end
        else if (mis_q)
        begin
            bus_rdata_q[7:0] <= read_byte(mis_addr_q + 16'h0001); // R01
            bus_ack_q        <= 1'b1;
            mis_q            <= 1'b0;
        end
        else if (take_rd && misaligned)
        begin
            bus_rdata_q[15:8] <= read_byte(bus_req.addr);        // R01
            mis_addr_q        <= bus_req.addr;
            mis_q             <= 1'b1;
        end
        else if (take_rd)
        begin
            bus_rdata_q <= bus_req.word ?
                {read_byte(bus_req.addr),
                 read_byte(bus_req.addr + 16'h0001)} :
                {8'h00, read_byte(bus_req.addr)};                // R01
            bus_ack_q   <= 1'b1;
        end
        else if (take_wr)
            bus_ack_q <= 1'b1;                                   // R17
    end

    // module_configuration
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            mcr_hi_q   <= shadow_q[7:4];                         // R09
            wcs_q      <= 1'b0;
            plk_q      <= 1'b0;
            plk_used_q <= 1'b0;
            pcs_q      <= 1'b0;
        end
        else if (take_wr && wr_hits(EAC_OFS_MCR))
        begin
            if (!normal_mode_flag)                               // R11
            begin
                mcr_hi_q[EAC_MCR_DLD - 4] <= mcr_wr[EAC_MCR_DLD];
                mcr_hi_q[EAC_MCR_SHD - 4] <= mcr_wr[EAC_MCR_SHD];
            end
            wcs_q <= mcr_wr[EAC_MCR_WCS];                        // R08
            pcs_q <= mcr_wr[EAC_MCR_PCS];                        // R13
            if (!normal_mode_flag || !plk_used_q)                // R12
            begin
                plk_q      <= mcr_wr[EAC_MCR_PLK];
                plk_used_q <= 1'b1;
            end
        end
    end

    // block_protect
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            prot_q <= EAC_PROT_RESET;                            // R15
        else if (take_wr && wr_hits(EAC_OFS_PROT) &&
                 !pg_q[EAC_PG_PGM] && !plk_q)                    // R14
            prot_q <= wr_lane(EAC_OFS_PROT) | EAC_PROT_FIXED;    // R15
    end

    // program control
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            pg_q <= 8'h00;
        else if (take_wr && wr_hits(EAC_OFS_PGMCTL))
        begin
            if (!pg_q[EAC_PG_PGM])                               // R21
            begin
                pg_q[EAC_PG_BYTE]  <= pg_wr[EAC_PG_BYTE];
                pg_q[EAC_PG_ROW]   <= pg_wr[EAC_PG_ROW];
                pg_q[EAC_PG_ERASE] <= pg_wr[EAC_PG_ERASE];
                pg_q[EAC_PG_LAT]   <= pg_wr[EAC_PG_LAT];
                if (!plk_q)                                      // R12
                    pg_q[EAC_PG_BULK_PROTECT] <= pg_wr[EAC_PG_BULK_PROTECT];
            end
            // enable only rises from an already set latch bit
            pg_q[EAC_PG_PGM] <= pg_wr[EAC_PG_PGM] &&
                                pg_q[EAC_PG_LAT];                // R20
        end
    end

    // address and data latch, frozen once voltage is enabled
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
            latch_q <= '0;
        else if (take_wr && in_array && pg_q[EAC_PG_LAT] &&
                 !pg_q[EAC_PG_PGM])                              // R21
        begin
            latch_q.idx  <= bus_req.addr[9:0];
            latch_q.word <= bus_req.word && !bus_req.addr[0];    // R02
            latch_q.data <= bus_req.wdata;
        end
    end

    eac_pump #(
        .TICKS  (PROG_TICKS),
        .RC_DIV (RC_DIV)
    ) u_pump (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .clk_en     (mod_en),                                    // R08
        .armed      (pg_q[EAC_PG_PGM]),
        .hv_on      (prog_voltage_on),                           // R07
        .rc_sel     (pcs_q),                                     // R13
        .rc_run     (rc_osc_run),
        .pulse_done (commit)
    );

    // commit once per voltage pulse; bulk and row need bulk guard clear
    always_ff @(posedge ref_clk)
    begin
        if (commit && !(pg_q[EAC_PG_ERASE] && !pg_q[EAC_PG_BYTE] &&
                        pg_q[EAC_PG_BULK_PROTECT]))
        begin
            for (int i = 0; i < EAC_ARRAY_BYTES; i++)
            begin
                if (in_target(10'(i)) && !region_prot(10'(i)) &&
                    !reserved_idx(10'(i)) &&
                    !(10'(i) == EAC_SHADOW_IDX && shadow_on))    // R10
                    mem_q[i] <= pg_q[EAC_PG_ERASE] ? EAC_ERASED  // R04
                              : mem_q[i] & prog_data(10'(i));    // R03
            end
            if (shadow_on && in_target(EAC_SHADOW_IDX) &&
                !prot_q[EAC_PROT_SHP])                           // R15
                shadow_q <= pg_q[EAC_PG_ERASE] ? EAC_ERASED
                          : shadow_q & prog_data(EAC_SHADOW_IDX);
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_mis_read;
        take_rd && misaligned;
    endsequence

    sequence s_two_beat;
        !bus_ack_q ##1 bus_ack_q;
    endsequence

    chk_aligned_read: assert property ( // R01
        take_rd && !misaligned |=> bus_ack_q && !mis_q)
        else $error("aligned read not answered in one cycle");

    chk_misaligned_read: assert property ( // R01
        s_mis_read |=> s_two_beat)
        else $error("misaligned read not answered in two cycles");

    chk_pgm_needs_lat: assert property ( // R20
        $rose(pg_q[EAC_PG_PGM]) |-> $past(pg_q[EAC_PG_LAT]))
        else $error("enable set without latch");

    chk_ctl_frozen: assert property ( // R21
        $past(pg_q[EAC_PG_PGM]) |-> $stable(pg_q[7:1]) && $stable(latch_q))
        else $error("control or latch changed while enabled");

    chk_prot_locked: assert property ( // R14
        $past(pg_q[EAC_PG_PGM] || plk_q) |-> $stable(prot_q))
        else $error("block protect changed while locked");

    chk_prot_fixed: assert property ( // R15
        prot_q[6:5] == 2'b11)
        else $error("fixed protect bits cleared");

    chk_stop_voltage: assert property ( // R07
        stop_req |-> !prog_voltage_on && !rc_osc_run)
        else $error("voltage or rc clock active in stop");

    chk_resume_voltage: assert property ( // R07
        $fell(stop_req) && pg_q[EAC_PG_PGM] |-> prog_voltage_on)
        else $error("voltage not restored after stop");

    chk_rc_select: assert property ( // R13
        !pcs_q |-> !rc_osc_run)
        else $error("rc oscillator runs with system clock selected");

    chk_wait_gate: assert property ( // R08
        wait_req && wcs_q |=> $stable(pg_q) && $stable(prot_q) &&
                              !bus_ack_q)
        else $error("module active while gated in wait");

    chk_array_gate: assert property ( // R06
        in_array && !array_access_enable |-> !bus_hit)
        else $error("array decoded while disabled");

    chk_shadow_load: assert property ( // R09
        disable iff (1'b0)
        !resetn |=> mcr_hi_q == $past(shadow_q[7:4]))
        else $error("shadow byte not loaded at reset");

endmodule : eac_top

// ==== testbench/eac_cpu_model.sv ====
`timescale 1ns/10ps
module eac_cpu_model
    import eac_pkg::*;
(
    input  wire logic        ref_clk,     // bus clock
    input  wire logic        bus_ack_q,   // answer strobe
    input  wire logic [15:0] bus_rdata_q, // read data
    output eac_bus_req_t     bus_req      // one-cycle request
);
    initial bus_req = '0;

    // pulse one request; lines are scrambled after the take so a stale
    // address or data value can never be mistaken for a live one
    task automatic acc(input  logic [15:0] a,
                       input  logic [15:0] d,
                       input  logic        w,
                       input  logic        r,
                       output logic [15:0] q,
                       output int          lat);
        int n;
        n   = 0;
        lat = 0;
        q   = 16'h0000;
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, rd: r, wr: !r, word: w};
        @(posedge ref_clk);
        bus_req <= '{addr: ~a, wdata: ~d, rd: 1'b0, wr: 1'b0, word: ~w};
        // ack stands for one cycle only, so look right after each edge
        while (lat == 0 && n < 6)
        begin
            #1;
            n++;
            if (bus_ack_q === 1'b1)
            begin
                lat = n;
                q   = bus_rdata_q;
            end
            else
                @(posedge ref_clk);
        end
    endtask : acc
endmodule : eac_cpu_model

// ==== testbench/eac_top_tb.sv ====
`timescale 1ns/10ps
module eac_top_tb;
    import eac_pkg::*;
    localparam int TICKS = 4;
    localparam int DIV   = 2;
    logic         ref_clk;
    logic         resetn;
    eac_bus_req_t bus_req;
    logic         array_access_enable;
    logic         normal_mode_flag;
    logic         stop_req;
    logic         wait_req;
    logic [15:0]  bus_rdata_q;
    logic         bus_ack_q;
    logic         prog_voltage_on;
    logic         rc_osc_run;
    logic         debug_lockout_en;
    logic         pcs;
    int           error_cnt;
    int           checks;

    eac_top #(.PROG_TICKS(TICKS), .RC_DIV(DIV)) eac_top_i (
        .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req),
        .array_access_enable(array_access_enable),
        .normal_mode_flag(normal_mode_flag), .stop_req(stop_req),
        .wait_req(wait_req), .bus_rdata_q(bus_rdata_q),
        .bus_ack_q(bus_ack_q), .bus_hit(), .prog_voltage_on(prog_voltage_on),
        .rc_osc_run(rc_osc_run), .debug_lockout_en(debug_lockout_en));
    eac_cpu_model eac_cpu_model_i (
        .ref_clk(ref_clk), .bus_ack_q(bus_ack_q),
        .bus_rdata_q(bus_rdata_q), .bus_req(bus_req));

    task automatic chk(input string nm, input logic [15:0] got,
                       input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic w);
        logic [15:0] q;
        int          lat;
        eac_cpu_model_i.acc(a, d, w, 1'b0, q, lat);
    endtask : wr

    // elat 0 means no answer is expected at all
    task automatic rd(input logic [15:0] a, input logic w,
                      input logic [15:0] exp, input int elat);
        logic [15:0] q;
        int          lat;
        eac_cpu_model_i.acc(a, 16'h0000, w, 1'b1, q, lat);
        chk("latency", 16'(lat), 16'(elat));
        if (elat != 0)
            chk("read data", q, exp);
    endtask : rd

    // one pulse; callers only program erased cells
    task automatic prog(input logic [15:0] a, input logic [15:0] d,
                        input logic w, input logic [7:0] ctl);
        wr(EAC_OFS_PGMCTL, {8'h00, ctl}, 1'b0);
        wr(a, d, w);
        wr(EAC_OFS_PGMCTL, {8'h00, ctl | 8'h01}, 1'b0);
        wr(a, 16'h0000, w);
        chk("voltage", {15'h0, prog_voltage_on}, 16'h0001);
        chk("rc run", {15'h0, rc_osc_run}, {15'h0, pcs});
        @(posedge ref_clk);
        stop_req <= 1'b1;
        rd(EAC_OFS_PGMCTL, 1'b0, {8'h00, ctl | 8'h01}, 1);
        chk("stop voltage", {15'h0, prog_voltage_on}, 16'h0000);
        chk("stop rc", {15'h0, rc_osc_run}, 16'h0000);
        @(posedge ref_clk);
        stop_req <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("voltage back", {15'h0, prog_voltage_on}, 16'h0001);
        repeat (TICKS * DIV + 4) @(posedge ref_clk);
        wr(EAC_OFS_PGMCTL, {8'h00, ctl}, 1'b0);
        wr(EAC_OFS_PGMCTL, 16'h0000, 1'b0);
    endtask : prog

    task automatic t_reset;
        rd(EAC_OFS_MCR, 1'b0, 16'h00F0, 1);
        chk("lockout", {15'h0, debug_lockout_en}, 16'h0000);
        rd(EAC_OFS_PROT, 1'b0, 16'h00FF, 1);
        rd(EAC_OFS_PGMCTL, 1'b0, 16'h0000, 1);
        wr(EAC_OFS_PRESCALE, 16'h5A5A, 1'b1);
        rd(EAC_OFS_PRESCALE, 1'b0, 16'h0000, 1);
        rd(16'h0BFF, 1'b0, 16'h0000, 0);
        rd(EAC_ARRAY_HI, 1'b0, 16'h00FF, 1);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_program;
        wr(EAC_OFS_PGMCTL, 16'h0003, 1'b0);
        rd(EAC_OFS_PGMCTL, 1'b0, 16'h0002, 1);
        wr(EAC_OFS_PGMCTL, 16'h0000, 1'b0);
        wr(EAC_OFS_PROT, 16'h0000, 1'b0);
        rd(EAC_OFS_PROT, 1'b0, 16'h0060, 1);
        prog(16'h0C10, 16'h00A5, 1'b0, 8'h02);
        rd(16'h0C10, 1'b0, 16'h00A5, 1);
        rd(16'h0C10, 1'b1, 16'hA5FF, 1);
        rd(16'h0C0F, 1'b1, 16'hFFA5, 2);
        prog(16'h0C21, 16'h1234, 1'b1, 8'h02);
        rd(16'h0C20, 1'b1, 16'hFF34, 1);
        rd(16'h0C22, 1'b0, 16'h00FF, 1);
        prog(16'h0C10, 16'h0000, 1'b0, 8'h16);
        rd(16'h0C10, 1'b0, 16'h00FF, 1);
        prog(16'h0C20, 16'h0000, 1'b0, 8'h0E);
        rd(16'h0C20, 1'b1, 16'hFFFF, 1);
        wr(EAC_OFS_PROT, 16'h0001, 1'b0);
        prog(16'h0FD0, 16'h0000, 1'b0, 8'h02);
        rd(16'h0FD0, 1'b0, 16'h00FF, 1);
        prog(16'h0C40, 16'h0000, 1'b0, 8'h02);
        prog(16'h0C40, 16'h0000, 1'b0, 8'h86);
        rd(16'h0C40, 1'b0, 16'h0000, 1);
        prog(16'h0C40, 16'h0000, 1'b0, 8'h06);
        rd(16'h0C40, 1'b0, 16'h00FF, 1);
        wr(EAC_OFS_PROT, 16'h0000, 1'b0);
        $display("test program erase done");
    endtask : t_program

    task automatic t_shadow;
        pcs = 1'b1;
        wr(EAC_OFS_MCR, 16'h0001, 1'b0);
        prog(16'h0FC0, 16'h007F, 1'b0, 8'h02);
        rd(16'h0FC0, 1'b0, 16'h007F, 1);
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        pcs = 1'b0;
        rd(EAC_OFS_MCR, 1'b0, 16'h0070, 1);
        chk("lockout", {15'h0, debug_lockout_en}, 16'h0001);
        rd(16'h0FC0, 1'b0, 16'h00FF, 1);
        $display("test shadow done");
    endtask : t_shadow

    task automatic t_lock_wait;
        @(posedge ref_clk);
        normal_mode_flag <= 1'b1;
        wr(EAC_OFS_MCR, 16'h0082, 1'b0);
        rd(EAC_OFS_MCR, 1'b0, 16'h0072, 1);
        wr(EAC_OFS_PROT, 16'h0000, 1'b0);
        rd(EAC_OFS_PROT, 1'b0, 16'h00FF, 1);
        wr(EAC_OFS_MCR, 16'h0004, 1'b0);
        rd(EAC_OFS_MCR, 1'b0, 16'h0076, 1);
        @(posedge ref_clk);
        wait_req <= 1'b1;
        rd(EAC_OFS_PROT, 1'b0, 16'h0000, 0);
        @(posedge ref_clk);
        wait_req <= 1'b0;
        rd(EAC_OFS_PROT, 1'b0, 16'h00FF, 1);
        @(posedge ref_clk);
        array_access_enable <= 1'b0;
        rd(16'h0C10, 1'b0, 16'h0000, 0);
        rd(EAC_OFS_PROT, 1'b0, 16'h00FF, 1);
        $display("test lock wait enable done");
    endtask : t_lock_wait

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial
    begin
        resetn = 1'b0;
        array_access_enable = 1'b1;
        normal_mode_flag = 1'b0;
        stop_req = 1'b0;
        wait_req = 1'b0;
        pcs = 1'b0;
        error_cnt = 0;
        checks = 0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset;
        t_program;
        t_shadow;
        t_lock_wait;
        tally_and_finish;
    end

    // about five thousand cycles, several times the expected run
    initial
    begin
        #200000;
        error_cnt++;
        tally_and_finish;
    end
endmodule : eac_top_tb
